// ==== bench/brs_sequencer_tb_top.sv ====
// testbench: register-level tests of the brown-out reset sequencer
`timescale 1ns/1ps
module brs_sequencer_tb_top;
    // ********************
    // setup
    // ********************
    // short timer keeps the power-up delay at eighty cycles
    localparam longint PUT_N = 8;
    localparam int SLOW_P = 10;
    localparam int OSC_P = 2;
    localparam int POR_N = 16;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic clk_en = 1'b1;
    logic low_hi = 1'b0, low_lo = 1'b0, erase = 1'b0;
    logic slow_tick = 1'b0, osc_tick = 1'b0;
    logic pin_n = 1'b1, sleeping = 1'b0, wdt = 1'b0, wake = 1'b0;
    logic [15:0] pc = 16'h1234;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, chip_reset, thr, pc_load_en, irq, thr1;
    logic [15:0] pc_load;
    int n_mismatch = 0;
    int num_checks = 0;
    int tick_cnt = 0;
    int cyc, exp_cyc;

    always #2.5 clk = ~clk;

    // free-running tick sources for the slow and main oscillators
    always @(posedge clk) begin
        tick_cnt <= tick_cnt + 1;
        slow_tick <= (tick_cnt % SLOW_P) == 0;
        osc_tick <= (tick_cnt % OSC_P) == 0;
    end

    brs_sequencer #(.PUT_CYCLES(PUT_N)) u_dut (
        .i_ref_clk(clk), .i_srst(srst), .i_clk_en(clk_en),
        .i_supply_low_hi(low_hi), .i_supply_low_lo(low_lo),
        .i_slow_tick(slow_tick), .i_osc_tick(osc_tick),
        .i_flash_erase(erase), .i_external_reset_pin_n(pin_n),
        .i_sleeping(sleeping), .i_wdt_timeout(wdt), .i_wake_irq(wake),
        .i_pc(pc), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_chip_reset(chip_reset),
        .o_brownout_threshold(thr), .o_pc_load(pc_load),
        .o_pc_load_en(pc_load_en), .o_irq(irq)
    );

    // ********************
    // tasks
    // ********************
    task automatic test_done();
        if (n_mismatch == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    // read data is registered at the access edge, so it is taken one edge on
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // the wait for the answer ends on pready; with no cycle limit only the watchdog ends a hang
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        rd = prdata;
    endtask

    task automatic wait_cr(input logic v, input int max);
        cyc = 0;
        while (chip_reset !== v && cyc < max) begin
            @(posedge clk);
            cyc++;
        end
    endtask

    task automatic st_chk(input logic [1:0] e, input string msg);
        apb(1'b0, brs_pkg::STATUS_ADDR, 32'h0);
        chk({rd[brs_pkg::STATUS_TO_BIT], rd[brs_pkg::STATUS_PDN_BIT]} === e,
            msg);
    endtask

    task automatic pulse_wdt();
        wdt <= 1'b1;
        @(posedge clk);
        wdt <= 1'b0;
    endtask

    task automatic pc_chk();
        cyc = 0;
        while (pc_load_en !== 1'b1 && cyc < 40) begin
            @(posedge clk);
            cyc++;
        end
        chk(pc_load === pc + 16'h0001, "wake pc");
        sleeping <= 1'b0;
    endtask

    // ********************
    // tests
    // ********************
    initial begin
        #300000;
        n_mismatch++;
        test_done();
    end

    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        exp_cyc = POR_N + PUT_N * SLOW_P + 1024 * OSC_P;
        wait_cr(1'b0, 5000);
        chk(cyc >= exp_cyc - SLOW_P - 4 && cyc <= exp_cyc + SLOW_P + 4, "lp delay");
        st_chk(2'b11, "status after power-on");
        apb(1'b0, brs_pkg::PWRCTL_ADDR, 32'h0);
        chk(rd[brs_pkg::PWRCTL_POR_BIT] === 1'b0, "power-on flag");
        apb(1'b0, brs_pkg::CFG_ADDR, 32'h0);
        chk(rd === 32'(brs_pkg::CFG_RST), "cfg reset");
        apb(1'b0, 12'h100, 32'h0);
        chk(err === 1'b1 && rd === 32'h0, "unmapped read");
        apb(1'b1, brs_pkg::MASK_ADDR, 32'h1);
        chk(irq === 1'b1, "irq on power-on event");
        apb(1'b0, brs_pkg::EVT_ADDR, 32'h0);
        chk(rd[0] === 1'b1, "power-on event");
        chk(irq === 1'b0, "irq after clear");
        apb(1'b1, brs_pkg::MASK_ADDR, 32'h0);
        apb(1'b1, brs_pkg::PWRCTL_ADDR, 32'h3);
        // trip select bit flips the threshold output
        apb(1'b1, brs_pkg::CFG_ADDR, 32'h07);
        thr1 = thr;
        apb(1'b1, brs_pkg::CFG_ADDR, 32'h03);
        chk(thr !== thr1 && (thr === 1'b0 || thr === 1'b1), "trip select");
        // a dip shorter than the minimum duration must not trip
        low_hi <= 1'b1;
        low_lo <= 1'b1;
        repeat (10) @(posedge clk);
        low_hi <= 1'b0;
        low_lo <= 1'b0;
        wait_cr(1'b1, 30);
        chk(cyc == 30, "short dip ignored");
        apb(1'b1, brs_pkg::CFG_ADDR, 32'h00);
        low_hi <= 1'b1;
        low_lo <= 1'b1;
        wait_cr(1'b1, 60);
        chk(cyc == 60, "detector off");
        apb(1'b1, brs_pkg::CFG_ADDR, 32'h02);
        sleeping <= 1'b1;
        wait_cr(1'b1, 60);
        chk(cyc == 60, "awake-only mode in sleep");
        apb(1'b1, brs_pkg::CFG_ADDR, 32'h4b);
        sleeping <= 1'b1;
        wait_cr(1'b1, 60);
        chk(cyc >= 18 && cyc <= 26, "trip time");
        low_hi <= 1'b0;
        low_lo <= 1'b0;
        wait_cr(1'b0, 3000);
        chk(cyc <= 6, "ec without timer: no delay");
        sleeping <= 1'b0;
        apb(1'b0, brs_pkg::PWRCTL_ADDR, 32'h0);
        chk(rd[1:0] === 2'b10, "flags after brown-out");
        st_chk(2'b11, "status after brown-out");
        chk(irq === 1'b0, "masked event");
        apb(1'b1, brs_pkg::MASK_ADDR, 32'h2);
        chk(irq === 1'b1, "unmasked brown-out event");
        apb(1'b0, brs_pkg::EVT_ADDR, 32'h0);
        chk(rd[1] === 1'b1 && irq === 1'b0, "event read clears");
        // second dip in mid power-up timer must restart the full count
        apb(1'b1, brs_pkg::CFG_ADDR, 32'h33);
        low_hi <= 1'b1;
        low_lo <= 1'b1;
        wait_cr(1'b1, 60);
        low_hi <= 1'b0;
        low_lo <= 1'b0;
        repeat (4 * SLOW_P) @(posedge clk);
        chk(chip_reset === 1'b1, "timer holds reset");
        low_hi <= 1'b1;
        low_lo <= 1'b1;
        repeat (40) @(posedge clk);
        low_hi <= 1'b0;
        low_lo <= 1'b0;
        wait_cr(1'b0, 3000);
        chk(cyc >= (PUT_N - 1) * SLOW_P && cyc <= (PUT_N + 1) * SLOW_P + 4, "restart");
        // erase forces detection at the low threshold
        apb(1'b1, brs_pkg::CFG_ADDR, 32'h4c);
        erase <= 1'b1;
        low_lo <= 1'b1;
        @(posedge clk);
        chk(thr === 1'b0, "erase threshold");
        wait_cr(1'b1, 60);
        chk(cyc < 60, "erase forces detector");
        low_lo <= 1'b0;
        erase <= 1'b0;
        wait_cr(1'b0, 3000);
        pin_n <= 1'b0;
        repeat (5) @(posedge clk);
        chk(chip_reset === 1'b1, "pin holds reset");
        pin_n <= 1'b1;
        wait_cr(1'b0, 3000);
        st_chk(2'b11, "pin reset running");
        pulse_wdt();
        wait_cr(1'b0, 3000);
        st_chk(2'b01, "watchdog reset");
        sleeping <= 1'b1;
        pin_n <= 1'b0;
        repeat (5) @(posedge clk);
        pin_n <= 1'b1;
        wait_cr(1'b0, 3000);
        sleeping <= 1'b0;
        st_chk(2'b10, "pin reset in sleep");
        sleeping <= 1'b1;
        pulse_wdt();
        pc_chk();
        st_chk(2'b00, "watchdog wake");
        sleeping <= 1'b1;
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        pc_chk();
        st_chk(2'b10, "interrupt wake");
        apb(1'b0, brs_pkg::CFG_ADDR, 32'h0);
        chk(rd === 32'h4c, "cfg kept over wake");
        // power-on with the pin held low: delays run behind it
        pin_n <= 1'b0;
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        repeat (exp_cyc + 200) @(posedge clk);
        chk(chip_reset === 1'b1, "pin low after power-on");
        pin_n <= 1'b1;
        wait_cr(1'b0, 10);
        chk(cyc <= 3, "release starts at once");
        // with the enable low the trip filter must not count
        clk_en <= 1'b0;
        low_lo <= 1'b1;
        repeat (40) @(posedge clk);
        chk(chip_reset === 1'b0, "enable low freezes filter");
        low_lo <= 1'b0;
        clk_en <= 1'b1;
        test_done();
    end
endmodule

// ==== logic/brs_pkg.sv ====
// package: constants for the brown-out reset sequencer
package brs_pkg;
    // ********************
    // register map (apb byte addresses, status word index)
    // ********************
    localparam logic [11:0] STATUS_IDX = 12'h003;
    localparam logic [11:0] STATUS_ADDR = 12'h00c;
    localparam logic [11:0] PWRCTL_ADDR = 12'h010;
    localparam logic [11:0] CFG_ADDR = 12'h014;
    localparam logic [11:0] EVT_ADDR = 12'h018;
    localparam logic [11:0] MASK_ADDR = 12'h01c;
    localparam logic [11:0] PC_ADDR = 12'h020;
    // ********************
    // field positions
    // ********************
    localparam int STATUS_PDN_BIT = 3;
    localparam int STATUS_TO_BIT = 4;
    localparam int PWRCTL_BRO_BIT = 0;
    localparam int PWRCTL_POR_BIT = 1;
    localparam int CFG_BREN_LSB = 0;
    localparam int CFG_BTRIP_BIT = 2;
    localparam int CFG_PUTD_BIT = 3;
    localparam int CFG_OSC_LSB = 4;
    // ********************
    // reset values
    // ********************
    localparam logic [7:0] STATUS_RST = 8'h18;
    localparam logic [7:0] CFG_RST = 8'h03;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [15:0] PC_VECTOR = 16'h0000;
    // ********************
    // enable codes
    // ********************
    localparam logic [1:0] BREN_ALWAYS = 2'h3;
    localparam logic [1:0] BREN_AWAKE = 2'h2;
    // ********************
    // timing
    // ********************
    localparam int CLK_MHZ = 200;
    localparam int PUT_MS = 64;
    localparam longint PUT_CYC = longint'(PUT_MS) * 1000 * CLK_MHZ;
    localparam int OSU_PERIODS = 1024;
    localparam int POR_PULSE_CYC = 16;
    localparam int BRO_MIN_NS = 100;
    localparam int BRO_MIN_CYC = (BRO_MIN_NS * CLK_MHZ + 999) / 1000;
    // ********************
    // types
    // ********************
    typedef enum logic [2:0] {
        ST_POR = 3'b000,
        ST_PUT = 3'b001,
        ST_OSU = 3'b010,
        ST_RUN = 3'b011,
        ST_BRO = 3'b100
    } brs_state_t;
    typedef enum logic [2:0] {
        OSC_LOWPWR = 3'b000,
        OSC_STDXTAL = 3'b001,
        OSC_FASTXTAL = 3'b010,
        OSC_RESCAP = 3'b011,
        OSC_EXTCLK = 3'b100,
        OSC_INT = 3'b101
    } brs_osc_t;
endpackage

// ==== logic/brs_sequencer.sv ====
// module: brown-out reset sequencer with apb register slave
// Operation
// - decode brown-out enable field 11/10/0x
// - one bit selects brown-out threshold
// - trip after low supply exceeds minimum duration
// - brown-out during power-up timer restarts it
// - flash erase forces brown-out on, low threshold
// - power-on pulse, power-up timer, oscillator timer order
// - external clock, timer disabled: no delay
// - delays run regardless of reset pin
// - crystal modes add 1024 oscillator periods
// - power control bit0 brown-out, bit1 power-on
// - brown-out flag cleared by brown-out reset
// - brown-out flag undefined when detection off
// - power-on flag cleared only on power-on
// - time-out and power-down flags per cause
// - sleep wake-up keeps registers, pc advances
// - power-up timer on slow clock holds reset
// - timer disable bit set disables power-up timer
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module brs_sequencer #(
    parameter longint PUT_CYCLES = brs_pkg::PUT_CYC
) (
    // clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_clk_en,
    // supply and timing sources
    input wire logic i_supply_low_hi,
    input wire logic i_supply_low_lo,
    input wire logic i_slow_tick,
    input wire logic i_osc_tick,
    input wire logic i_flash_erase,
    // core events
    input wire logic i_external_reset_pin_n,
    input wire logic i_sleeping,
    input wire logic i_wdt_timeout,
    input wire logic i_wake_irq,
    input wire logic [15:0] i_pc,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // outputs
    output logic o_chip_reset,
    output logic o_brownout_threshold,
    output logic [15:0] o_pc_load,
    output logic o_pc_load_en,
    output logic o_irq
);
    // ********************
    // registers
    // ********************
    brs_pkg::brs_state_t state_q, state_d;
    logic [7:0] cfg_q;
    logic [7:0] status_q;
    logic [1:0] pwrctl_q;
    logic [2:0] evt_q;
    logic [2:0] mask_q;
    logic [15:0] pc_q;
    logic [31:0] cnt_q;
    logic [10:0] osu_q;
    logic [7:0] low_q;
    logic [31:0] prdata_q;
    logic pc_en_q;
    logic first_q;

    // ********************
    // configuration decode
    // ********************
    wire [1:0] bren = cfg_q[brs_pkg::CFG_BREN_LSB +: 2];
    wire [2:0] osc = cfg_q[brs_pkg::CFG_OSC_LSB +: 3];
    wire put_en = ~cfg_q[brs_pkg::CFG_PUTD_BIT];
    wire crystal = (osc == brs_pkg::OSC_LOWPWR) |
                   (osc == brs_pkg::OSC_STDXTAL) |
                   (osc == brs_pkg::OSC_FASTXTAL);
    // erase forces low threshold on, whatever the config says
    wire bro_on = i_flash_erase | (bren == brs_pkg::BREN_ALWAYS) |
                  ((bren == brs_pkg::BREN_AWAKE) & ~i_sleeping);
    assign o_brownout_threshold = i_flash_erase ? 1'b0 :
                                  cfg_q[brs_pkg::CFG_BTRIP_BIT];
    wire low_now = o_brownout_threshold ? i_supply_low_hi : i_supply_low_lo;
    // filter: a trip needs the low level held the minimum duration
    wire bro_trip = bro_on & low_now &
                    (low_q >= 8'(brs_pkg::BRO_MIN_CYC - 1));
    wire put_done = (cnt_q >= 32'(PUT_CYCLES - 1)) & i_slow_tick;
    wire osu_done = (osu_q == 11'(brs_pkg::OSU_PERIODS - 1)) & i_osc_tick;
    wire por_done = cnt_q >= 32'(brs_pkg::POR_PULSE_CYC - 1);

    // ********************
    // apb decode
    // ********************
    wire acc = i_psel & i_penable;
    wire wr = acc & i_pwrite;
    wire rd_status = acc & ~i_pwrite & (i_paddr == brs_pkg::STATUS_ADDR);
    wire rd_evt = acc & ~i_pwrite & (i_paddr == brs_pkg::EVT_ADDR);
    wire hit = (i_paddr == brs_pkg::STATUS_ADDR) |
               (i_paddr == brs_pkg::PWRCTL_ADDR) |
               (i_paddr == brs_pkg::CFG_ADDR) |
               (i_paddr == brs_pkg::EVT_ADDR) |
               (i_paddr == brs_pkg::MASK_ADDR) |
               (i_paddr == brs_pkg::PC_ADDR);
    assign o_pready = 1'b1;
    assign o_pslverr = acc & ~hit;
    assign o_prdata = prdata_q;
    wire [31:0] rd_mux =
        (i_paddr == brs_pkg::STATUS_ADDR) ? {24'h000000, status_q} :
        (i_paddr == brs_pkg::PWRCTL_ADDR) ? {30'h00000000, pwrctl_q} :
        (i_paddr == brs_pkg::CFG_ADDR) ? {24'h000000, cfg_q} :
        (i_paddr == brs_pkg::EVT_ADDR) ? {29'h00000000, evt_q} :
        (i_paddr == brs_pkg::MASK_ADDR) ? {29'h00000000, mask_q} :
        (i_paddr == brs_pkg::PC_ADDR) ? {16'h0000, pc_q} : 32'h00000000;

    // ********************
    // time-out sequence
    // ********************
    // chip held in reset through every pre-run state and while pin is low
    assign o_chip_reset = (state_q != brs_pkg::ST_RUN) |
                          ~i_external_reset_pin_n;
    always_comb begin
        state_d = state_q;
        case (state_q)
            brs_pkg::ST_POR: begin
                if (por_done) begin
                    // no delay at all for ec with timer disabled
                    state_d = put_en ? brs_pkg::ST_PUT :
                              crystal ? brs_pkg::ST_OSU :
                              brs_pkg::ST_RUN;
                end
            end
            brs_pkg::ST_BRO: begin
                if (!(bro_on & low_now)) begin
                    state_d = put_en ? brs_pkg::ST_PUT :
                              crystal ? brs_pkg::ST_OSU :
                              brs_pkg::ST_RUN;
                end
            end
            brs_pkg::ST_PUT: begin
                if (put_done) begin
                    state_d = crystal ? brs_pkg::ST_OSU :
                              brs_pkg::ST_RUN;
                end
            end
            brs_pkg::ST_OSU: begin
                if (osu_done) begin
                    state_d = brs_pkg::ST_RUN;
                end
            end
            brs_pkg::ST_RUN: state_d = brs_pkg::ST_RUN;
            default: state_d = brs_pkg::ST_POR;
        endcase
        if (bro_trip && state_q != brs_pkg::ST_POR) begin
            state_d = brs_pkg::ST_BRO;
        end
    end

    wire enter_bro = bro_trip & (state_q != brs_pkg::ST_BRO) &
                     (state_q != brs_pkg::ST_POR);
    wire pin_reset = ~i_external_reset_pin_n & (state_q == brs_pkg::ST_RUN);
    wire wdt_reset = i_wdt_timeout & ~i_sleeping &
                     (state_q == brs_pkg::ST_RUN);
    wire wdt_wake = i_wdt_timeout & i_sleeping &
                    (state_q == brs_pkg::ST_RUN);
    wire irq_wake = i_wake_irq & i_sleeping & (state_q == brs_pkg::ST_RUN);
    wire [2:0] evt_set = {pin_reset | wdt_reset, enter_bro,
                          first_q};

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            state_q <= brs_pkg::ST_POR;
            cnt_q <= 32'h00000000;
            osu_q <= 11'h000;
            low_q <= 8'h00;
        end else if (i_clk_en) begin
            state_q <= state_d;
            low_q <= (bro_on & low_now) ?
                     ((low_q == 8'hff) ? low_q : low_q + 8'h01) : 8'h00;
            if (state_d != state_q || state_q == brs_pkg::ST_BRO) begin
                cnt_q <= 32'h00000000;
            end else if (state_q == brs_pkg::ST_POR ||
                         (state_q == brs_pkg::ST_PUT && i_slow_tick)) begin
                cnt_q <= cnt_q + 32'h00000001;
            end
            if (state_q != brs_pkg::ST_OSU) begin
                osu_q <= 11'h000;
            end else if (i_osc_tick) begin
                osu_q <= osu_q + 11'h001;
            end
        end
    end

    // ********************
    // status, power control, pc
    // ********************
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            status_q <= brs_pkg::STATUS_RST;
            // brown-out flag has no defined power-on value; zero chosen
            pwrctl_q <= 2'h0;
            pc_q <= brs_pkg::PC_VECTOR;
            pc_en_q <= 1'b0;
            first_q <= 1'b1;
        end else if (i_clk_en) begin
            first_q <= 1'b0;
            pc_en_q <= 1'b0;
            if (wr && i_paddr == brs_pkg::STATUS_ADDR) begin
                status_q <= i_pwdata[7:0];
            end
            if (wr && i_paddr == brs_pkg::PWRCTL_ADDR) begin
                pwrctl_q <= i_pwdata[1:0];
            end
            // power-on flag is left alone: only a power-on clears it
            if (enter_bro) begin
                pwrctl_q[brs_pkg::PWRCTL_BRO_BIT] <= 1'b0;
                status_q[brs_pkg::STATUS_TO_BIT] <= 1'b1;
                status_q[brs_pkg::STATUS_PDN_BIT] <= 1'b1;
            end else if (wdt_reset) begin
                status_q[brs_pkg::STATUS_TO_BIT] <= 1'b0;
            end else if (wdt_wake) begin
                status_q[brs_pkg::STATUS_TO_BIT] <= 1'b0;
                status_q[brs_pkg::STATUS_PDN_BIT] <= 1'b0;
            end else if (pin_reset && i_sleeping) begin
                status_q[brs_pkg::STATUS_TO_BIT] <= 1'b1;
                status_q[brs_pkg::STATUS_PDN_BIT] <= 1'b0;
            end else if (irq_wake) begin
                status_q[brs_pkg::STATUS_TO_BIT] <= 1'b1;
                status_q[brs_pkg::STATUS_PDN_BIT] <= 1'b0;
            end
            if (wdt_wake || irq_wake) begin
                pc_q <= i_pc + 16'h0001;
                pc_en_q <= 1'b1;
            end else if (enter_bro || pin_reset || wdt_reset) begin
                pc_q <= brs_pkg::PC_VECTOR;
                pc_en_q <= 1'b1;
            end
        end
    end
    assign o_pc_load = pc_q;
    assign o_pc_load_en = pc_en_q;

    // ********************
    // config, events, mask, read data
    // ********************
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            cfg_q <= brs_pkg::CFG_RST;
            mask_q <= brs_pkg::MASK_RST[2:0];
            evt_q <= 3'h0;
            prdata_q <= 32'h00000000;
        end else if (i_clk_en) begin
            if (wr && i_paddr == brs_pkg::CFG_ADDR) begin
                cfg_q <= i_pwdata[7:0];
            end
            if (wr && i_paddr == brs_pkg::MASK_ADDR) begin
                mask_q <= i_pwdata[2:0];
            end
            // new events win over the read clear
            evt_q <= (rd_evt ? 3'h0 : evt_q) | evt_set;
            if (acc && !i_pwrite) begin
                prdata_q <= rd_mux;
            end
        end
    end
    assign o_irq = |(evt_q & mask_q);

    // ********************
    // checks
    // ********************
    a_reset_held_off: assert property (@(posedge i_ref_clk)
        disable iff (i_srst)
        (state_q != brs_pkg::ST_RUN) |-> o_chip_reset)
        else $error("chip reset released before sequence done");
    a_bro_restart: assert property (@(posedge i_ref_clk)
        disable iff (i_srst)
        (i_clk_en && bro_trip && state_q == brs_pkg::ST_PUT) |=>
        (state_q == brs_pkg::ST_BRO && cnt_q == 32'h0))
        else $error("brown-out did not restart power-up timer");
    a_osu_after_put: assert property (@(posedge i_ref_clk)
        disable iff (i_srst)
        (state_q == brs_pkg::ST_OSU) |-> $past(state_q) != brs_pkg::ST_POR
        || !$past(put_en))
        else $error("oscillator timer started before power-up timer");
    a_bro_flag_clr: assert property (@(posedge i_ref_clk)
        disable iff (i_srst)
        (i_clk_en && enter_bro) |=>
        !pwrctl_q[brs_pkg::PWRCTL_BRO_BIT])
        else $error("brown-out flag not cleared");
    a_por_flag_kept: assert property (@(posedge i_ref_clk)
        disable iff (i_srst)
        (i_clk_en && enter_bro && !wr) |=>
        $stable(pwrctl_q[brs_pkg::PWRCTL_POR_BIT]))
        else $error("power-on flag changed by brown-out");
    a_wake_pc_adv: assert property (@(posedge i_ref_clk)
        disable iff (i_srst)
        (i_clk_en && irq_wake && !wdt_wake) |=>
        (o_pc_load == $past(i_pc) + 16'h0001 && o_pc_load_en))
        else $error("wake-up did not advance pc");
    a_wdt_to_clr: assert property (@(posedge i_ref_clk)
        disable iff (i_srst)
        (i_clk_en && wdt_reset && !enter_bro) |=>
        !status_q[brs_pkg::STATUS_TO_BIT])
        else $error("watchdog reset left time-out flag set");
    a_erase_forces: assert property (@(posedge i_ref_clk)
        disable iff (i_srst)
        i_flash_erase |-> (bro_on && !o_brownout_threshold))
        else $error("erase did not force brown-out on");
    a_no_delay_ec: assert property (@(posedge i_ref_clk)
        disable iff (i_srst)
        (i_clk_en && state_q == brs_pkg::ST_POR && por_done && !put_en
         && !crystal && !bro_trip) |=> state_q == brs_pkg::ST_RUN)
        else $error("delay applied with timer disabled");
endmodule
